// ==== hw/tgp_pkg.sv ====
// Constants shared by the three-port GPIO block and its testbench.
// Assumes a 100 MHz system clock and AXI4-Lite register access.
package tgp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_IRQ    = 8'hC0;
  localparam logic [7:0] IDX_FALL   = 8'hC2;
  localparam logic [7:0] IDX_RISE   = 8'hC3;
  localparam logic [7:0] IDX_SLEEP  = 8'hE1;
  localparam logic [7:0] IDX_ISTAT  = 8'hF8;
  localparam logic [7:0] IDX_IMASK  = 8'hF9;
  localparam logic [2:0][7:0] IDX_DATA = {8'hC5, 8'hC4, 8'hC1};
  localparam logic [2:0][7:0] IDX_DIR  = {8'hDA, 8'hD5, 8'hD0};
  localparam logic [2:0][7:0] IDX_PU   = {8'hDB, 8'hD6, 8'hD1};
  localparam logic [2:0][7:0] IDX_PD   = {8'hDC, 8'hD7, 8'hD2};
  localparam logic [1:0][7:0] IDX_ITYP = {8'hD8, 8'hD3};
  localparam logic [1:0][7:0] IDX_OTYP = {8'hD9, 8'hD4};

  // Field positions
  localparam int EXT_BIT   = 5;
  localparam int INT_RISE  = 0;
  localparam int INT_FALL  = 1;
  localparam int INT_WAKE  = 2;
  localparam int INT_BITS  = 3;

  // Input type: ones mean Schmitt, zeros mean Schmitt, ones mean dimmer
  localparam logic [7:0] ITYP_SCHM_HI = 8'h27;
  localparam logic [7:0] ITYP_SCHM_LO = 8'hC0;
  localparam logic [7:0] ITYP_DIM     = 8'h18;
  // Output type: bits that carry the carrier while data is zero
  localparam logic [7:0] OTYP_DATA0   = 8'hAA;

  localparam logic [7:0] REG_RST      = 8'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // Carrier timing
  localparam int CLK_HZ     = 100_000_000;
  localparam int CARRIER_HZ = 37_400;
  localparam logic [10:0] CAR_HALF_M1 = 11'(CLK_HZ / (2 * CARRIER_HZ) - 1);
endpackage

// ==== hw/tgp_sync_if.sv ====
// Carrier between the GPIO core and its pin-input filter.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface tgp_sync_if #(parameter int W = 24);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport core (output raw, input level, input rise, input fall);
  modport filt (input raw, output level, output rise, output fall);
endinterface
`default_nettype wire

// ==== hw/tgp_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes raw pins are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module tgp_pin_sync #(
  parameter int W = 24
) (
  // Clock and control
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   ce,
  // Pin levels in, filtered levels and edges out
  tgp_sync_if.filt    sif
);
  if (W < 1) begin : g_bad_w
    $error("tgp_pin_sync: W must be positive");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } tgp_sync_t;

  tgp_sync_t s;
  tgp_sync_t next_s;
  logic [W-1:0] chg;

  always_comb begin
    next_s      = s;
    next_s.s1   = sif.raw;
    next_s.s2   = s.s1;
    next_s.s3   = s.s2;
    // Accept a change once the second and third stages agree
    chg         = ~(s.s2 ^ s.s3) & (s.s3 ^ s.lvl);
    next_s.lvl  = s.lvl ^ chg;
    next_s.rise = chg & s.s3;
    next_s.fall = chg & ~s.s3;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign sif.level = s.lvl;
  assign sif.rise  = s.rise;
  assign sif.fall  = s.fall;

  a_sync_agree: assert property (@(posedge clk) disable iff (rst)
    ce && (s.s2 != s.s3) |=> ((s.lvl ^ $past(s.lvl)) & $past(s.s2 ^ s.s3)) == '0)
    else $error("filtered level moved while stages disagreed");
endmodule // tgp_pin_sync
`default_nettype wire

// ==== hw/tgp_gpio.sv ====
// Three-port GPIO with port-1 edge flags, wake from sleep and carrier output.
// Assumes an AXI4-Lite master on CLK and pads that resolve out/oe/pulls.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
//Contract
// - Each port-1 pin sets its rising-edge flag on a low-to-high change, readable as one byte.
// - Clearing the external interrupt flag clears every port-1 rising-edge flag.
// - Writing zero to a rising-flag bit clears that flag and disables rising detection.
// - Ports 2 and 3 have byte-wide readable and writable data registers.
// - Each port has a write-only direction register where one makes the pin an output.
// - Each port has a pull-up enable, forced off while the pin drives low.
// - Each port has a pull-low enable, forced off while the pin drives low.
// - Input type bits 0,1,2,5 pick Schmitt on one and bits 6,7 pick Schmitt on zero.
// - Input type bits 3 and 4 pick the dimmer input on one.
// - Output type zero gives a plain output that follows the data bit.
// - Output type one gives a 37.4kHz carrier, even bits on data one, odd on data zero.
// - Direction, pull, input and output type registers reset to zero.
// - Writing the sleep register stops the oscillator until an enabled port-1 edge.
// - Port 1 has a byte-wide readable and writable data register.
// - Falling-edge flags set on high-to-low, clear and disable on zero, reset to zero.
// - The external flag is bit 5 of the interrupt flag register, cleared by writing zero.
module tgp_gpio #(
  parameter int AW = 12
) (
  // Clock, reset, enable
  input  wire logic          CLK,
  input  wire logic          RST,
  input  wire logic          CE,
  // AXI4-Lite write address
  input  wire logic [AW-1:0] AWADDR,
  input  wire logic [2:0]    AWPROT,
  input  wire logic          AWVALID,
  output logic               AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0]   WDATA,
  input  wire logic [3:0]    WSTRB,
  input  wire logic          WVALID,
  output logic               WREADY,
  // AXI4-Lite write response
  output logic [1:0]         BRESP,
  output logic               BVALID,
  input  wire logic          BREADY,
  // AXI4-Lite read address
  input  wire logic [AW-1:0] ARADDR,
  input  wire logic [2:0]    ARPROT,
  input  wire logic          ARVALID,
  output logic               ARREADY,
  // AXI4-Lite read data
  output logic [31:0]        RDATA,
  output logic [1:0]         RRESP,
  output logic               RVALID,
  input  wire logic          RREADY,
  // Port 1 pads
  input  wire logic [7:0]    FIRST_PORT_PINS_IN,
  output logic [7:0]         FIRST_PORT_PINS_OUT,
  output logic [7:0]         FIRST_PORT_PINS_OE,
  output logic [7:0]         FIRST_PORT_PINS_PU,
  output logic [7:0]         FIRST_PORT_PINS_PD,
  output logic [7:0]         FIRST_PORT_PINS_SCHMITT,
  output logic [7:0]         FIRST_PORT_PINS_DIMMER,
  // Port 2 pads
  input  wire logic [7:0]    SECOND_PORT_PINS_IN,
  output logic [7:0]         SECOND_PORT_PINS_OUT,
  output logic [7:0]         SECOND_PORT_PINS_OE,
  output logic [7:0]         SECOND_PORT_PINS_PU,
  output logic [7:0]         SECOND_PORT_PINS_PD,
  output logic [7:0]         SECOND_PORT_PINS_SCHMITT,
  output logic [7:0]         SECOND_PORT_PINS_DIMMER,
  // Port 3 pads
  input  wire logic [7:0]    THIRD_PORT_PINS_IN,
  output logic [7:0]         THIRD_PORT_PINS_OUT,
  output logic [7:0]         THIRD_PORT_PINS_OE,
  output logic [7:0]         THIRD_PORT_PINS_PU,
  output logic [7:0]         THIRD_PORT_PINS_PD,
  // System
  output logic               SLEEP_REQ,
  output logic               EXT_FLAG,
  output logic               IRQ
);
  if (AW < 10 || AW > 32) begin : g_bad_aw
    $error("tgp_gpio: AW must be 10 to 32");
  end

  localparam int INT_BITS_W = tgp_pkg::INT_BITS;

  typedef struct packed {
    logic                    aw_got;
    logic                    aw_bad;
    logic [7:0]              awi;
    logic                    w_got;
    logic [7:0]              wd;
    logic                    wstb;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [1:0]              rresp;
    logic [7:0]              rdata;
    logic [2:0][7:0]         dat;
    logic [2:0][7:0]         dir;
    logic [2:0][7:0]         pu;
    logic [2:0][7:0]         pd;
    logic [1:0][7:0]         ityp;
    logic [1:0][7:0]         otyp;
    logic [7:0]              rise_en;
    logic [7:0]              fall_en;
    logic [7:0]              rise_f;
    logic [7:0]              fall_f;
    logic                    ext_f;
    logic                    sleep;
    logic                    carrier;
    logic [10:0]             ccnt;
    logic [INT_BITS_W-1:0]   ist;
    logic [INT_BITS_W-1:0]   imask;
    logic                    irq;
    logic [2:0][7:0]         pout;
    logic [2:0][7:0]         poe;
    logic [2:0][7:0]         ppu;
    logic [2:0][7:0]         ppd;
    logic [1:0][7:0]         psch;
    logic [1:0][7:0]         pdim;
  } tgp_state_t;

  tgp_state_t s;
  tgp_state_t next_s;

  tgp_sync_if #(.W(24)) sif ();

  tgp_pin_sync #(.W(24)) u_sync (
    .clk (CLK),
    .rst (RST),
    .ce  (CE),
    .sif (sif)
  );

  assign sif.raw = {THIRD_PORT_PINS_IN, SECOND_PORT_PINS_IN, FIRST_PORT_PINS_IN};

  logic [7:0] rise_set;
  logic [7:0] fall_set;
  logic       any_ev;
  assign rise_set = sif.rise[7:0] & s.rise_en;
  assign fall_set = sif.fall[7:0] & s.fall_en;
  assign any_ev   = |(rise_set | fall_set);

  function automatic logic mapped(input logic [7:0] ix);
    mapped = 1'b0;
    for (int p = 0; p < 3; p++) begin
      if (ix == tgp_pkg::IDX_DATA[p] || ix == tgp_pkg::IDX_DIR[p] ||
          ix == tgp_pkg::IDX_PU[p] || ix == tgp_pkg::IDX_PD[p]) begin
        mapped = 1'b1;
      end
    end
    for (int p = 0; p < 2; p++) begin
      if (ix == tgp_pkg::IDX_ITYP[p] || ix == tgp_pkg::IDX_OTYP[p]) begin
        mapped = 1'b1;
      end
    end
    if (ix == tgp_pkg::IDX_IRQ || ix == tgp_pkg::IDX_FALL || ix == tgp_pkg::IDX_RISE ||
        ix == tgp_pkg::IDX_SLEEP || ix == tgp_pkg::IDX_ISTAT ||
        ix == tgp_pkg::IDX_IMASK) begin
      mapped = 1'b1;
    end
  endfunction

  logic                  do_wr;
  logic                  wen;
  logic                  ext_clr;
  logic                  slp_set;
  logic [7:0]            rise_clr;
  logic [7:0]            fall_clr;
  logic [7:0]            rix;
  logic [7:0]            rd;
  logic                  lvl;
  logic [INT_BITS_W-1:0] ist_clr;
  logic [INT_BITS_W-1:0] ev;

  always_comb begin
    next_s   = s;
    ext_clr  = 1'b0;
    slp_set  = 1'b0;
    rise_clr = 8'h00;
    fall_clr = 8'h00;
    ist_clr  = '0;
    lvl      = 1'b0;
    rd       = 8'h00;
    rix      = ARADDR[9:2];
    do_wr    = s.aw_got && s.w_got && !s.bvalid;
    wen      = do_wr && s.wstb && !s.aw_bad;

    // Write address and data, taken in either order
    if (AWVALID && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awi    = AWADDR[9:2];
      next_s.aw_bad = (AW > 10) ? (|(AWADDR >> 10)) : 1'b0;
    end
    if (WVALID && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wd    = WDATA[7:0];
      next_s.wstb  = WSTRB[0];
    end
    if (s.bvalid && BREADY) begin
      next_s.bvalid = 1'b0;
    end
    if (do_wr) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = (!s.aw_bad && mapped(s.awi)) ? tgp_pkg::RESP_OKAY
                                                    : tgp_pkg::RESP_SLVERR;
    end

    // Register writes
    if (wen) begin
      for (int p = 0; p < 3; p++) begin
        if (s.awi == tgp_pkg::IDX_DATA[p]) next_s.dat[p] = s.wd;
        if (s.awi == tgp_pkg::IDX_DIR[p])  next_s.dir[p] = s.wd;
        if (s.awi == tgp_pkg::IDX_PU[p])   next_s.pu[p]  = s.wd;
        if (s.awi == tgp_pkg::IDX_PD[p])   next_s.pd[p]  = s.wd;
      end
      for (int p = 0; p < 2; p++) begin
        if (s.awi == tgp_pkg::IDX_ITYP[p]) next_s.ityp[p] = s.wd;
        if (s.awi == tgp_pkg::IDX_OTYP[p]) next_s.otyp[p] = s.wd;
      end
      if (s.awi == tgp_pkg::IDX_IRQ && !s.wd[tgp_pkg::EXT_BIT]) begin
        ext_clr = 1'b1;
      end
      if (s.awi == tgp_pkg::IDX_RISE) begin
        next_s.rise_en = s.wd;
        rise_clr       = ~s.wd;
      end
      if (s.awi == tgp_pkg::IDX_FALL) begin
        next_s.fall_en = s.wd;
        fall_clr       = ~s.wd;
      end
      if (s.awi == tgp_pkg::IDX_SLEEP) slp_set = 1'b1;
      if (s.awi == tgp_pkg::IDX_ISTAT) ist_clr = s.wd[INT_BITS_W-1:0];
      if (s.awi == tgp_pkg::IDX_IMASK) next_s.imask = s.wd[INT_BITS_W-1:0];
    end

    // Clearing the external flag wipes every edge flag
    if (ext_clr) begin
      rise_clr = 8'hFF;
      fall_clr = 8'hFF;
    end
    // New edges win over a clear in the same cycle
    next_s.rise_f = (s.rise_f & ~rise_clr) | rise_set;
    next_s.fall_f = (s.fall_f & ~fall_clr) | fall_set;
    next_s.ext_f  = (s.ext_f & ~ext_clr) | any_ev;

    // Sleep until an enabled port-1 edge
    next_s.sleep = slp_set | (s.sleep & ~any_ev);

    ev                   = '0;
    ev[tgp_pkg::INT_RISE] = |rise_set;
    ev[tgp_pkg::INT_FALL] = |fall_set;
    ev[tgp_pkg::INT_WAKE] = s.sleep & any_ev;
    next_s.ist = (s.ist & ~ist_clr) | ev;
    next_s.irq = |(next_s.ist & next_s.imask);

    // Reads
    if (s.rvalid && RREADY) begin
      next_s.rvalid = 1'b0;
    end
    if (ARVALID && s.arready) begin
      for (int p = 0; p < 3; p++) begin
        if (rix == tgp_pkg::IDX_DATA[p]) begin
          rd = (s.dir[p] & s.dat[p]) | (~s.dir[p] & sif.level[p*8 +: 8]);
        end
      end
      if (rix == tgp_pkg::IDX_IRQ)   rd[tgp_pkg::EXT_BIT] = s.ext_f;
      if (rix == tgp_pkg::IDX_RISE)  rd = s.rise_f;
      if (rix == tgp_pkg::IDX_FALL)  rd = s.fall_f;
      if (rix == tgp_pkg::IDX_ISTAT) rd[INT_BITS_W-1:0] = s.ist;
      if (rix == tgp_pkg::IDX_IMASK) rd[INT_BITS_W-1:0] = s.imask;
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd;
      next_s.rresp  = ((AW > 10 && |(ARADDR >> 10)) || !mapped(rix)) ?
                      tgp_pkg::RESP_SLVERR : tgp_pkg::RESP_OKAY;
    end

    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready  = !next_s.w_got && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;

    // Carrier half-period counter
    if (s.ccnt >= tgp_pkg::CAR_HALF_M1) begin
      next_s.ccnt    = 11'h000;
      next_s.carrier = ~s.carrier;
    end else begin
      next_s.ccnt = s.ccnt + 11'h001;
    end

    // Pad drive
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 8; i++) begin
        lvl = next_s.dat[p][i];
        if (p < 2 && next_s.otyp[p][i]) begin
          lvl = next_s.carrier &
                (tgp_pkg::OTYP_DATA0[i] ? ~next_s.dat[p][i] : next_s.dat[p][i]);
        end
        next_s.pout[p][i] = lvl;
        next_s.ppu[p][i]  = next_s.pu[p][i] & ~(next_s.dir[p][i] & ~lvl);
        next_s.ppd[p][i]  = next_s.pd[p][i] & ~(next_s.dir[p][i] & ~lvl);
      end
      next_s.poe[p] = next_s.dir[p];
    end
    for (int p = 0; p < 2; p++) begin
      next_s.psch[p] = (next_s.ityp[p] & tgp_pkg::ITYP_SCHM_HI) |
                       (~next_s.ityp[p] & tgp_pkg::ITYP_SCHM_LO);
      next_s.pdim[p] = next_s.ityp[p] & tgp_pkg::ITYP_DIM;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s <= '0;
    end else if (CE) begin
      s <= next_s;
    end
  end

  assign AWREADY                  = s.awready;
  assign WREADY                   = s.wready;
  assign BVALID                   = s.bvalid;
  assign BRESP                    = s.bresp;
  assign ARREADY                  = s.arready;
  assign RVALID                   = s.rvalid;
  assign RRESP                    = s.rresp;
  assign RDATA                    = {24'h000000, s.rdata};
  assign FIRST_PORT_PINS_OUT      = s.pout[0];
  assign FIRST_PORT_PINS_OE       = s.poe[0];
  assign FIRST_PORT_PINS_PU       = s.ppu[0];
  assign FIRST_PORT_PINS_PD       = s.ppd[0];
  assign FIRST_PORT_PINS_SCHMITT  = s.psch[0];
  assign FIRST_PORT_PINS_DIMMER   = s.pdim[0];
  assign SECOND_PORT_PINS_OUT     = s.pout[1];
  assign SECOND_PORT_PINS_OE      = s.poe[1];
  assign SECOND_PORT_PINS_PU      = s.ppu[1];
  assign SECOND_PORT_PINS_PD      = s.ppd[1];
  assign SECOND_PORT_PINS_SCHMITT = s.psch[1];
  assign SECOND_PORT_PINS_DIMMER  = s.pdim[1];
  assign THIRD_PORT_PINS_OUT      = s.pout[2];
  assign THIRD_PORT_PINS_OE       = s.poe[2];
  assign THIRD_PORT_PINS_PU       = s.ppu[2];
  assign THIRD_PORT_PINS_PD       = s.ppd[2];
  assign SLEEP_REQ                = s.sleep;
  assign EXT_FLAG                 = s.ext_f;
  assign IRQ                      = s.irq;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence wr_rise_seq;
    CE && wen && s.awi == tgp_pkg::IDX_RISE;
  endsequence
  sequence wr_ext_clr_seq;
    CE && wen && s.awi == tgp_pkg::IDX_IRQ && !s.wd[tgp_pkg::EXT_BIT];
  endsequence

  a_rise_flag_set: assert property (
    CE |=> ((s.rise_f & $past(rise_set)) == $past(rise_set)))
    else $error("enabled rising edge did not set its flag");
  a_ext_clear_all: assert property (
    wr_ext_clr_seq ##0 !any_ev |=> s.rise_f == 8'h00 && s.fall_f == 8'h00 && !s.ext_f)
    else $error("external flag clear left edge flags set");
  a_rise_write_zero: assert property (
    wr_rise_seq |=> s.rise_en == $past(s.wd) &&
                    (s.rise_f & ~$past(s.wd) & ~$past(rise_set)) == 8'h00)
    else $error("zero written to rising flag did not clear and disable");
  a_fall_flag_set: assert property (
    CE |=> ((s.fall_f & $past(fall_set)) == $past(fall_set)))
    else $error("enabled falling edge did not set its flag");
  a_dir_drives_oe: assert property (
    CE |=> s.poe == $past(next_s.dir) && FIRST_PORT_PINS_OE == s.dir[0])
    else $error("output enable does not follow direction");
  a_pull_off_low: assert property (
    ((s.poe[2] & ~s.pout[2] & (s.ppu[2] | s.ppd[2])) == 8'h00) &&
    ((s.poe[0] & ~s.pout[0] & (s.ppu[0] | s.ppd[0])) == 8'h00))
    else $error("pull stays on at a pin driving low");
  a_carrier_half: assert property (
    CE && s.ccnt == tgp_pkg::CAR_HALF_M1 |=> s.carrier != $past(s.carrier) && s.ccnt == 11'h000)
    else $error("carrier half period wrong");
  a_plain_output: assert property (
    CE && next_s.otyp[1] == 8'h00 |=> SECOND_PORT_PINS_OUT == s.dat[1])
    else $error("plain output does not follow data");
  a_reset_zero: assert property (
    $past(RST) |-> s.dir == '0 && s.pu == '0 && s.pd == '0 && s.ityp == '0 && s.otyp == '0)
    else $error("configuration not zero after reset");
  a_sleep_wake: assert property (
    CE && s.sleep && any_ev && !(wen && s.awi == tgp_pkg::IDX_SLEEP) |=> !SLEEP_REQ)
    else $error("enabled port-1 edge did not wake the device");
  a_schmitt_map: assert property (
    (FIRST_PORT_PINS_SCHMITT & tgp_pkg::ITYP_DIM) == 8'h00 &&
    (FIRST_PORT_PINS_DIMMER & ~tgp_pkg::ITYP_DIM) == 8'h00)
    else $error("input type decode overlaps");
endmodule // tgp_gpio
`default_nettype wire

// ==== testbench/tgp_pins_model.sv ====
// Board model of the 24 port pads: resolves block drive, board drive and pulls.
// Assumes one bit per pin, port 1 in bits 7:0, port 3 in bits 23:16.
`timescale 1ns/1ps
`default_nettype none
module tgp_pins_model (
  // Clock
  input  wire logic        clk,
  // Pad controls from the block
  input  wire logic [23:0] out,
  input  wire logic [23:0] oe,
  input  wire logic [23:0] pu,
  input  wire logic [23:0] pd,
  // Board drive
  input  wire logic [23:0] drv,
  input  wire logic [23:0] drv_en,
  // Resolved pad levels
  output logic      [23:0] pin
);
  logic [23:0] last = 24'h000000;

  // Undriven unpulled pads wander every cycle
  always @(posedge clk) begin
    last <= pin;
  end
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      pin[i] = oe[i] ? out[i] : drv_en[i] ? drv[i] : pu[i] ? 1'b1 : pd[i] ? 1'b0 : ~last[i];
    end
  end
endmodule // tgp_pins_model
`default_nettype wire

// ==== testbench/tgp_gpio_tb.sv ====
// Self-checking bench for the three-port GPIO block over AXI4-Lite.
// Assumes tgp_pkg, the design and the pad model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tgp_gpio_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0]  wstrb = 4'h1;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic        bready = 1'b0;
  logic        rready = 1'b0;
  logic        ce = 1'b1;
  logic [23:0] drv = 24'hA0A000;
  logic [23:0] drv_en = 24'hFFFFFF;
  wire logic   awready, wready, bvalid, arready, rvalid, ext_flag, irq, sleep_req;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [23:0] p_out, p_oe, p_pu, p_pd, p_in;
  wire logic [15:0] p_sch, p_dim;
  int          failures = 0;
  int          checked = 0;
  int          cyc = 0;

  tgp_gpio #(.AW(12)) DUT (
    .CLK(clk), .RST(rst), .CE(ce),
    .AWADDR(awaddr), .AWPROT(3'h0), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARPROT(3'h0), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .FIRST_PORT_PINS_IN(p_in[7:0]), .FIRST_PORT_PINS_OUT(p_out[7:0]),
    .FIRST_PORT_PINS_OE(p_oe[7:0]), .FIRST_PORT_PINS_PU(p_pu[7:0]),
    .FIRST_PORT_PINS_PD(p_pd[7:0]), .FIRST_PORT_PINS_SCHMITT(p_sch[7:0]),
    .FIRST_PORT_PINS_DIMMER(p_dim[7:0]),
    .SECOND_PORT_PINS_IN(p_in[15:8]), .SECOND_PORT_PINS_OUT(p_out[15:8]),
    .SECOND_PORT_PINS_OE(p_oe[15:8]), .SECOND_PORT_PINS_PU(p_pu[15:8]),
    .SECOND_PORT_PINS_PD(p_pd[15:8]), .SECOND_PORT_PINS_SCHMITT(p_sch[15:8]),
    .SECOND_PORT_PINS_DIMMER(p_dim[15:8]),
    .THIRD_PORT_PINS_IN(p_in[23:16]), .THIRD_PORT_PINS_OUT(p_out[23:16]),
    .THIRD_PORT_PINS_OE(p_oe[23:16]), .THIRD_PORT_PINS_PU(p_pu[23:16]),
    .THIRD_PORT_PINS_PD(p_pd[23:16]),
    .SLEEP_REQ(sleep_req), .EXT_FLAG(ext_flag), .IRQ(irq)
  );
  tgp_pins_model pads (.clk(clk), .out(p_out), .oe(p_oe), .pu(p_pu), .pd(p_pd),
                       .drv(drv), .drv_en(drv_en), .pin(p_in));

  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", bresp, tgp_pkg::RESP_OKAY);
  endtask
  task automatic rc(input string nm, input logic [7:0] idx, input logic [7:0] e,
                    input logic [1:0] er = tgp_pkg::RESP_OKAY);
    @(posedge clk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(nm, rdata, {24'h000000, e});
    chk("rresp", rresp, er);
  endtask
  task automatic pad(input int i, input logic v);
    @(posedge clk);
    drv[i] <= v;
    repeat (8) @(posedge clk);
  endtask
  task automatic edge_wait(output int n, output logic [7:0] v);
    logic [7:0] s;
    s = p_out[7:0];
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (p_out[7:0] === s);
    v = p_out[7:0];
  endtask

  task automatic t_reset();
    @(negedge clk);
    chk("sch", p_sch, 16'hC0C0);
    chk("oe", p_oe, 24'h000000);
    chk("pu", p_pu, 24'h000000);
    chk("pd", p_pd, 24'h000000);
    chk("dim", p_dim, 16'h0000);
    rc("wo", tgp_pkg::IDX_DIR[0], 8'h00);
    rc("unmapped", 8'h10, 8'h00, tgp_pkg::RESP_SLVERR);
  endtask
  task automatic t_ports();
    logic [7:0] e;
    @(posedge clk);
    drv_en <= 24'h00FFFF;
    for (int p = 0; p < 3; p++) begin
      wr(tgp_pkg::IDX_DIR[p], 8'h0F);
      wr(tgp_pkg::IDX_DATA[p], 8'h05);
      wr(tgp_pkg::IDX_PU[p], 8'hFF);
      wr(tgp_pkg::IDX_PD[p], 8'hFF);
      repeat (8) @(posedge clk);
      e = (p == 2) ? 8'hF5 : 8'h05 | (drv[p*8+:8] & 8'hF0);
      rc("data", tgp_pkg::IDX_DATA[p], e);
      @(negedge clk);
      chk("oe", p_oe[p*8+:8], 8'h0F);
      chk("out", p_out[p*8+:8], 8'h05);
      chk("pu", p_pu[p*8+:8], 8'hF5);
      chk("pd", p_pd[p*8+:8], 8'hF5);
    end
    @(posedge clk);
    wstrb <= 4'h0;
    wr(tgp_pkg::IDX_DATA[1], 8'hFA);
    wstrb <= 4'h1;
    @(negedge clk);
    chk("strb", p_out[15:8], 8'h05);
    wr(tgp_pkg::IDX_DIR[0], 8'h00);
    wr(tgp_pkg::IDX_ITYP[0], 8'hFF);
    wr(tgp_pkg::IDX_ITYP[1], 8'hFF);
    @(negedge clk);
    chk("sch", p_sch, 16'h2727);
    chk("dim", p_dim, 16'h1818);
  endtask
  task automatic t_edges();
    wr(tgp_pkg::IDX_RISE, 8'hFF);
    wr(tgp_pkg::IDX_FALL, 8'hFF);
    pad(0, 1'b1);
    rc("rise", tgp_pkg::IDX_RISE, 8'h01);
    rc("irqf", tgp_pkg::IDX_IRQ, 8'h20);
    wr(tgp_pkg::IDX_RISE, 8'hFE);
    rc("rise", tgp_pkg::IDX_RISE, 8'h00);
    pad(0, 1'b0);
    pad(0, 1'b1);
    pad(7, 1'b1);
    rc("rise", tgp_pkg::IDX_RISE, 8'h80);
    rc("fall", tgp_pkg::IDX_FALL, 8'h01);
    wr(tgp_pkg::IDX_IRQ, 8'h00);
    rc("rise", tgp_pkg::IDX_RISE, 8'h00);
    rc("fall", tgp_pkg::IDX_FALL, 8'h00);
    @(negedge clk);
    chk("ext", ext_flag, 1'b0);
  endtask
  task automatic t_sleep();
    wr(tgp_pkg::IDX_IMASK, 8'h04);
    wr(tgp_pkg::IDX_SLEEP, 8'h01);
    @(negedge clk);
    chk("sleep", sleep_req, 1'b1);
    pad(7, 1'b0);
    chk("wake", sleep_req, 1'b0);
    chk("irq", irq, 1'b1);
    wr(tgp_pkg::IDX_IMASK, 8'h00);
    @(negedge clk);
    chk("mask", irq, 1'b0);
    wr(tgp_pkg::IDX_ISTAT, 8'h07);
    rc("stat", tgp_pkg::IDX_ISTAT, 8'h00);
  endtask
  task automatic t_carrier();
    int n;
    logic [7:0] a, b;
    wr(tgp_pkg::IDX_DIR[0], 8'hFF);
    wr(tgp_pkg::IDX_DATA[0], 8'h0F);
    @(negedge clk);
    chk("plain", p_out[7:0], 8'h0F);
    wr(tgp_pkg::IDX_OTYP[0], 8'hFF);
    edge_wait(n, a);
    edge_wait(n, a);
    edge_wait(n, b);
    // Half period: 100 MHz over 74.8 kHz, truncated
    chk("half", n, 1336);
    chk("car", a ^ b, 8'hA5);
    chk("car0", a & b, 8'h00);
    // Enable low must hold the carrier past a half period
    @(posedge clk);
    ce <= 1'b0;
    repeat (1400) @(posedge clk);
    chk("freeze", p_out[7:0], b);
    ce <= 1'b1;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_ports();
    t_edges();
    t_sleep();
    t_carrier();
    tally_and_finish();
  end
endmodule // tgp_gpio_tb
`default_nettype wire
